// ### upir_params.svh
`ifndef UPIR_PARAMS_SVH
`define UPIR_PARAMS_SVH

`define UPIR_ADDR_RISE_WR 6'h0D
`define UPIR_ADDR_RISE_SET 6'h0E
`define UPIR_ADDR_RISE_CLR 6'h0F
`define UPIR_ADDR_FALL_WR 6'h10
`define UPIR_ADDR_FALL_SET 6'h11
`define UPIR_ADDR_FALL_CLR 6'h12
`define UPIR_ADDR_STATUS 6'h13
`define UPIR_ADDR_LATCH 6'h14
`define UPIR_ADDR_DEBUG 6'h15
`define UPIR_ADDR_SPARE_WR 6'h16
`define UPIR_ADDR_SPARE_SET 6'h17
`define UPIR_ADDR_SPARE_CLR 6'h18

`define UPIR_BIT_HOST_DISC 0
`define UPIR_BIT_VBUS_VALID 1
`define UPIR_BIT_SESS_VALID 2
`define UPIR_BIT_SESS_END 3
`define UPIR_BIT_ID_GND 4

`define UPIR_RISE_RESET 5'h1F
`define UPIR_FALL_RESET 5'h1F
`define UPIR_SPARE_RESET 8'h00

`endif

// ### upir_pkg.sv
package upir_pkg;

  typedef struct packed {
    logic host_disc;
    logic id_gnd;
    logic sess_end;
    logic sess_valid;
    logic vbus_valid;
    logic [1:0] line_state;
  } upir_line_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } upir_req_t;

  typedef enum logic [1:0] {
    UPIR_OP_WRITE = 2'b00,
    UPIR_OP_SET = 2'b01,
    UPIR_OP_CLEAR = 2'b10,
    UPIR_OP_NONE = 2'b11
  } upir_op_t;

  // Three-address register write, set or clear
  function automatic logic [7:0] upir_apply(input logic [7:0] cur, input logic [7:0] wd,
                                             input upir_op_t op);
    logic [7:0] res;
    res = cur;
    unique case (op)
      UPIR_OP_WRITE: res = wd;
      UPIR_OP_SET: res = cur | wd;
      UPIR_OP_CLEAR: res = cur & ~wd;
      UPIR_OP_NONE: res = cur;
    endcase
    return res;
  endfunction : upir_apply

endpackage : upir_pkg

// ### upir_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
module upir_edge_detect (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Signals
  input wire logic [4:0] sig,
  input wire logic [4:0] rise_en,
  input wire logic [4:0] fall_en,
  // Events
  output logic [4:0] event_hit
);
  typedef struct packed {
    logic [4:0] prev;
  } upir_ed_state_t;

  upir_ed_state_t state;
  upir_ed_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.prev = sig; // RL16
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign event_hit = (sig & ~state.prev & rise_en) | (~sig & state.prev & fall_en); // RL16
endmodule : upir_edge_detect
`default_nettype wire

// ### upir_reg3.sv
`timescale 1ns/1ns
`default_nettype none
module upir_reg3 #(
  parameter logic [5:0] BASE = 6'h00,
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Access
  input wire logic wr,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  // Value
  output logic [7:0] value
);
  import upir_pkg::*;

  typedef struct packed {
    logic [7:0] value;
  } upir_r3_state_t;

  upir_r3_state_t state;
  upir_r3_state_t next_state;
  upir_op_t op;

  always_comb begin
    op = UPIR_OP_NONE;
    if (wr && addr == BASE) begin
      op = UPIR_OP_WRITE;
    end else if (wr && addr == 6'(BASE + 6'h01)) begin
      op = UPIR_OP_SET;
    end else if (wr && addr == 6'(BASE + 6'h02)) begin
      op = UPIR_OP_CLEAR;
    end
    next_state = state;
    next_state.value = upir_apply(state.value, wdata, op) & MASK; // RL15
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state.value <= RST_VAL;
    end else begin
      state <= next_state;
    end
  end

  assign value = state.value;
endmodule : upir_reg3
`default_nettype wire

// ### usb_phy_interrupt_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "upir_params.svh"
//
// Function
// RL1 - Rising enable: read 0x0D-0x0F; write 0x0D, set 0x0E, clear 0x0F.
// RL2 - Falling enable: read 0x10-0x12; write 0x10, set 0x11, clear 0x12.
// RL3 - Rising bits 0-4 per signal, reset one, enable low-to-high events; 7:5 zero.
// RL4 - Falling bits 0-4 per signal, reset one, enable high-to-low events; 7:5 zero.
// RL5 - Host-disconnect enable, status and latch act only in host mode.
// RL6 - Status at 0x13 shows live values of five signals; bits 7:5 zero.
// RL7 - VbusValid status reads zero when both its edge enables are set.
// RL8 - SessEnd status reads zero when both its edge enables are set.
// RL9 - SessValid status always shows live comparator output.
// RL10 - Zero status only right after reset; reads sample current state.
// RL11 - Latch at 0x14 sets bit per unmasked edge; resets zero; 7:5 zero.
// RL12 - Reading latch returns contents then clears it; read-only.
// RL13 - Debug at 0x15 shows LineState in 1:0; 7:2 zero; resets zero.
// RL14 - Scratch byte at 0x16-0x18, write/set/clear, reset zero, no side effect.
// RL15 - Set address ORs data in; clear address clears bits written as one.
// RL16 - Edges found by comparing with previous sample; enabled direction sets latch.
module usb_phy_interrupt_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register access from the link
  input wire upir_pkg::upir_req_t req,
  output logic [7:0] rdata,
  // Transceiver status
  input wire upir_pkg::upir_line_t line,
  input wire logic host_mode,
  // Event pending indication
  output logic event_pending
);
  import upir_pkg::*;

  typedef struct packed {
    logic [4:0] latch;
    logic [4:0] status;
    logic [1:0] line_state;
    logic [7:0] rdata;
  } upir_state_t;

  upir_state_t state;
  upir_state_t next_state;
  logic [7:0] rise_q;
  logic [7:0] fall_q;
  logic [7:0] spare_q;
  logic [4:0] live;
  logic [4:0] rise_eff;
  logic [4:0] fall_eff;
  logic [4:0] event_hit;
  logic [4:0] status_view;
  logic latch_read;

  upir_reg3 #(
    .BASE(`UPIR_ADDR_RISE_WR),
    .RST_VAL({3'h0, `UPIR_RISE_RESET}),
    .MASK(8'h1F)
  ) u_rise (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr(req.wr),
    .addr(req.addr),
    .wdata(req.wdata),
    .value(rise_q)
  ); // RL1 RL3

  upir_reg3 #(
    .BASE(`UPIR_ADDR_FALL_WR),
    .RST_VAL({3'h0, `UPIR_FALL_RESET}),
    .MASK(8'h1F)
  ) u_fall (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr(req.wr),
    .addr(req.addr),
    .wdata(req.wdata),
    .value(fall_q)
  ); // RL2 RL4

  upir_reg3 #(
    .BASE(`UPIR_ADDR_SPARE_WR),
    .RST_VAL(`UPIR_SPARE_RESET),
    .MASK(8'hFF)
  ) u_spare (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr(req.wr),
    .addr(req.addr),
    .wdata(req.wdata),
    .value(spare_q)
  ); // RL14

  assign live = {line.id_gnd, line.sess_end, line.sess_valid, line.vbus_valid,
                 line.host_disc & host_mode}; // RL5

  // Host-disconnect enables are gated so stray device-mode edges never latch
  always_comb begin
    rise_eff = rise_q[4:0];
    fall_eff = fall_q[4:0];
    rise_eff[`UPIR_BIT_HOST_DISC] = rise_q[`UPIR_BIT_HOST_DISC] & host_mode; // RL5
    fall_eff[`UPIR_BIT_HOST_DISC] = fall_q[`UPIR_BIT_HOST_DISC] & host_mode; // RL5
  end

  upir_edge_detect u_edge (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sig(live),
    .rise_en(rise_eff),
    .fall_en(fall_eff),
    .event_hit(event_hit)
  ); // RL16

  always_comb begin
    status_view = state.status; // RL6 RL9
    if (rise_q[`UPIR_BIT_VBUS_VALID] && fall_q[`UPIR_BIT_VBUS_VALID]) begin
      status_view[`UPIR_BIT_VBUS_VALID] = 1'b0; // RL7
    end
    if (rise_q[`UPIR_BIT_SESS_END] && fall_q[`UPIR_BIT_SESS_END]) begin
      status_view[`UPIR_BIT_SESS_END] = 1'b0; // RL8
    end
  end

  assign latch_read = req.rd && req.addr == `UPIR_ADDR_LATCH;

  always_comb begin
    next_state = state;
    // Status follows the lines every cycle; zero holds only until first sample
    next_state.status = live; // RL6 RL10
    next_state.line_state = line.line_state; // RL13
    // New events win over the read clear so none are lost
    if (latch_read) begin
      next_state.latch = event_hit; // RL12
    end else begin
      next_state.latch = state.latch | event_hit; // RL11
    end
    next_state.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `UPIR_ADDR_RISE_WR, `UPIR_ADDR_RISE_SET, `UPIR_ADDR_RISE_CLR: begin
          next_state.rdata = rise_q; // RL1
        end
        `UPIR_ADDR_FALL_WR, `UPIR_ADDR_FALL_SET, `UPIR_ADDR_FALL_CLR: begin
          next_state.rdata = fall_q; // RL2
        end
        `UPIR_ADDR_STATUS: begin
          next_state.rdata = {3'h0, status_view}; // RL6
        end
        `UPIR_ADDR_LATCH: begin
          next_state.rdata = {3'h0, state.latch}; // RL12
        end
        `UPIR_ADDR_DEBUG: begin
          next_state.rdata = {6'h00, state.line_state}; // RL13
        end
        `UPIR_ADDR_SPARE_WR, `UPIR_ADDR_SPARE_SET, `UPIR_ADDR_SPARE_CLR: begin
          next_state.rdata = spare_q; // RL14
        end
        default: begin
          next_state.rdata = 8'h00;
        end
      endcase
    end else begin
      next_state.rdata = state.rdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rdata = state.rdata;
  assign event_pending = |state.latch;
endmodule : usb_phy_interrupt_regs
`default_nettype wire

// ### upir_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module upir_link_model (
  // Clock
  input wire logic core_clk,
  // Register access
  output var upir_pkg::upir_req_t req,
  input wire logic [7:0] rdata
);
  import upir_pkg::*;
  initial req = '0;
  // Released fields show the inverse so a stale value never passes for a live one
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] w,
                      output logic [7:0] d);
    @(posedge core_clk);
    req <= '{rd: rd, wr: !rd, addr: a, wdata: w};
    @(posedge core_clk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~w};
    #1 d = rdata;
  endtask : xfer
endmodule : upir_link_model
`default_nettype wire

// ### upir_properties.sv
`timescale 1ns/1ns
`default_nettype none
module upir_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Observed ports
  input wire upir_pkg::upir_req_t req,
  input wire logic [7:0] rdata,
  input wire upir_pkg::upir_line_t line,
  input wire logic host_mode,
  input wire logic event_pending
);
  import upir_pkg::*;
  logic [2:0] quiet;
  logic rd13;
  logic rd14;
  assign rd13 = req.rd && req.addr == 6'h13;
  assign rd14 = req.rd && req.addr == 6'h14;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Status and latch are judged only once the inputs have settled
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) quiet <= 3'h0;
    else if (line != $past(line) || host_mode != $past(host_mode)) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  AST_HI_ZERO: assert property (req.rd && req.addr inside {[6'h0D:6'h14]} |=>
    rdata[7:5] == 3'h0) else $error("upper bits not zero");
  AST_SESS_VALID: assert property (rd13 && quiet >= 3'h3 |=>
    rdata[2] == $past(line.sess_valid)) else $error("session valid status wrong");
  AST_ID_GND: assert property (rd13 && quiet >= 3'h3 |=>
    rdata[4] == $past(line.id_gnd)) else $error("id status wrong");
  AST_HOST_GATE: assert property (rd13 && quiet >= 3'h3 && !host_mode |=>
    !rdata[0]) else $error("disconnect shown outside host mode");
  AST_DEBUG: assert property (req.rd && req.addr == 6'h15 && quiet >= 3'h3 |=>
    rdata == {6'h00, $past(line.line_state)}) else $error("debug read wrong");
  AST_SPARE: assert property ((req.wr && req.addr == 6'h16) ##1 !req.wr ##1
    (req.rd && req.addr == 6'h16) |=> rdata == $past(req.wdata, 3)) else $error("spare lost");
  AST_LATCH_CLR: assert property ((rd14 && quiet == 3'h7) ##2 rd14 |=>
    rdata == 8'h00) else $error("latch not cleared by read");
  AST_PENDING: assert property (rd14 && !$past(rd14) && quiet == 3'h7 |=>
    (rdata != 8'h00) == $past(event_pending)) else $error("pending and latch differ");
  cover property (rd14 ##1 rdata != 8'h00);
  cover property (rd13 && quiet >= 3'h3 && host_mode);
  cover property (req.wr && req.addr == 6'h17);
endmodule : upir_properties
bind usb_phy_interrupt_regs upir_properties u_upir_properties (.core_clk(core_clk),
  .rst_b(rst_b), .req(req), .rdata(rdata), .line(line), .host_mode(host_mode),
  .event_pending(event_pending));
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import upir_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic host_mode = 1'b0;
  upir_line_t line = '0;
  upir_req_t req;
  logic [7:0] rdata;
  logic [7:0] d;
  logic event_pending;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] lf = 32'hEFD6;
  logic [7:0] m [4] = '{8'h1F, 8'h1F, 8'h00, 8'h00};
  logic [7:0] m_lat = 8'h00;
  logic [4:0] m_sig = 5'h00;
  usb_phy_interrupt_regs u_usb_phy_interrupt_regs (.core_clk(core_clk), .rst_b(rst_b),
    .req(req), .rdata(rdata), .line(line), .host_mode(host_mode),
    .event_pending(event_pending));
  upir_link_model u_upir_link_model (.core_clk(core_clk), .req(req), .rdata(rdata));
  initial forever #2 core_clk = ~core_clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [7:0] expv(input logic [5:0] a);
    logic [4:0] s;
    s = m_sig;
    if (m[0][1] && m[1][1]) s[1] = 1'b0;
    if (m[0][3] && m[1][3]) s[3] = 1'b0;
    case (a)
      6'h0D, 6'h0E, 6'h0F: return m[0];
      6'h10, 6'h11, 6'h12: return m[1];
      6'h13: return {3'h0, s};
      6'h14: return m_lat;
      6'h15: return {6'h00, line.line_state};
      6'h16, 6'h17, 6'h18: return m[3];
      default: return 8'h00;
    endcase
  endfunction : expv
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [5:0] a);
    u_upir_link_model.xfer(1'b1, a, 8'h00, d);
    chk(d, expv(a));
    if (a == 6'h14) m_lat = 8'h00;
  endtask : rd
  task wr(input logic [5:0] a, input logic [7:0] w);
    int g;
    int o;
    logic [7:0] mk;
    g = (int'(a) - 13) / 3;
    o = (int'(a) - 13) % 3;
    mk = (g == 3) ? 8'hFF : 8'h1F;
    u_upir_link_model.xfer(1'b0, a, w, d);
    if (a >= 6'h0D && a <= 6'h18 && g != 2)
      m[g] = (o == 0) ? (w & mk) : (o == 1) ? (m[g] | (w & mk)) : (m[g] & ~w);
  endtask : wr
  task drive(input upir_line_t l, input logic h);
    logic [4:0] n;
    n = {l.id_gnd, l.sess_end, l.sess_valid, l.vbus_valid, l.host_disc & h};
    // Disconnect edges count only while host mode is on
    m_lat |= {3'h0, (~m_sig & n & m[0][4:0] & {4'hF, h}) | (m_sig & ~n & m[1][4:0] & {4'hF, h})};
    m_sig = n;
    @(posedge core_clk);
    line <= l;
    host_mode <= h;
    repeat (4) @(posedge core_clk);
    #1 chk({7'h00, event_pending}, {7'h00, m_lat != 8'h00});
  endtask : drive
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // Bounded run: a stuck sequence ends as a mismatch
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int a = 12; a < 26; a++) rd(6'(a));
    $display("test reset values done");
    repeat (60) begin
      lf = nxt(lf);
      wr(6'h0C + 6'(lf % 14), lf[15:8]);
      lf = nxt(lf);
      drive(upir_line_t'(lf[6:0]), lf[7]);
      for (int a = 12; a < 26; a++) rd(6'(a));
      rd(6'h14);
      rd(6'h14);
      wr(6'h16, lf[23:16]);
      rd(6'h16);
    end
    $display("test random traffic done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
